// file: design/svw_cnt.sv
// svw_cnt: saturating up-counter used for every interval of the watchdog core.
// assumes clear and run come from the same clock domain as clk.
`timescale 1ns/1ns
module svw_cnt #(
    parameter int unsigned W = 26
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic run,
    output logic [W-1:0] count_q
);

    logic [W-1:0] count_d;

    // saturate so a stalled interval never wraps back to a small value
    always_comb begin
        count_d = count_q;
        if (clear) begin
            count_d = '0;
        end else if (run && (count_q != {W{1'b1}})) begin
            count_d = count_q + W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule // svw_cnt

// file: design/svw_core.sv
// svw_core: digital core of a supply supervisor with a kick watchdog.
// assumes comparator, probe and charge inputs are already synchronous to clk;
// open-drain pins are given as level plus drive enable, pull-ups sit outside.
`timescale 1ns/1ns
// Contract
// RQ1 - reset low while supply below threshold
// RQ2 - hold reset after supply valid, then release
// RQ3 - reset hold nominally 200 ms
// RQ4 - reprobe select pin on each valid entry
// RQ5 - classify pin open, pulled up, capacitor
// RQ6 - fixed timeouts 1600 ms open, 200 ms pulled
// RQ7 - only falling kick edges act
// RQ8 - late kick drives fault output low
// RQ9 - interval measured falling edge to falling edge
// RQ10 - watchdog off, kicks ignored during reset
// RQ11 - watchdog resumes after reset release
// RQ12 - fault output held low for hold time
// RQ13 - fault output released while reset low
// RQ14 - enable low disables watchdog, ignores kicks
// RQ15 - enable high runs watchdog normally
// RQ16 - ignore kicks 140 us after enabling
// RQ17 - host keeps kick at solid level
// RQ18 - accepted kick restarts interval from zero
// RQ19 - capacitor mode ends on charge-done input
// RQ20 - after fault pulse restart interval
module svw_core #(
    parameter logic [25:0] HOLD_CYCLES = 26'(svw_pkg::HOLD_CYC),
    parameter logic [25:0] PROBE_CYCLES = 26'(svw_pkg::PROBE_CYC),
    parameter logic [25:0] TMO_OPEN_CYCLES = 26'(svw_pkg::TMO_OPEN_CYC),
    parameter logic [25:0] TMO_PULL_CYCLES = 26'(svw_pkg::TMO_PULL_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_low,
    input wire logic supply_valid,
    input wire svw_pkg::svw_probe_t probe_sense,
    input wire logic wdog_enable,
    input wire logic kick_in,
    input wire logic charge_done,
    output logic system_reset_out_n,
    output logic system_reset_oe,
    output logic wdog_fault_out_n,
    output logic wdog_fault_oe,
    output svw_pkg::svw_mode_t timeout_mode,
    output logic wdog_active,
    output logic charge_restart
);

    localparam logic [25:0] SETTLE_CYCLES = 26'(svw_pkg::SETTLE_CYC);

    svw_pkg::svw_sup_t sup_q, sup_d;
    svw_pkg::svw_mode_t mode_q, mode_d;
    logic probe_busy_q, probe_busy_d;
    logic rst_n_q, rst_n_d;
    logic [25:0] hold_cnt;
    logic [25:0] probe_cnt;
    logic hold_clr;

    // supply counters: the hold counter only runs while holding reset
    svw_cnt #(.W(svw_pkg::CNT_W)) u_hold_cnt (
        .clk(clk),
        .rst(rst),
        .clear(hold_clr),
        .run(1'b1),
        .count_q(hold_cnt)
    );

    svw_cnt #(.W(svw_pkg::CNT_W)) u_probe_cnt (
        .clk(clk),
        .rst(rst),
        .clear(!probe_busy_q),
        .run(1'b1),
        .count_q(probe_cnt)
    );

    // supply sequencing, pin probe and system reset level
    always_comb begin
        sup_d = sup_q;
        mode_d = mode_q;
        probe_busy_d = probe_busy_q;
        hold_clr = (sup_q != svw_pkg::SVW_S_HOLD);
        case (sup_q)
            svw_pkg::SVW_S_LOW: begin
                // RQ4 reprobe on entry
                if (supply_valid && !supply_low) begin
                    sup_d = svw_pkg::SVW_S_HOLD;
                    probe_busy_d = 1'b1;
                    mode_d = svw_pkg::SVW_MODE_NONE;
                end
            end
            svw_pkg::SVW_S_HOLD: begin
                // RQ2 RQ3 hold then release
                if (supply_low) begin
                    sup_d = svw_pkg::SVW_S_LOW;
                end else if (hold_cnt >= HOLD_CYCLES - 26'h0001) begin
                    sup_d = svw_pkg::SVW_S_RUN;
                end
            end
            svw_pkg::SVW_S_RUN: begin
                // RQ1 dropout asserts reset
                if (supply_low) begin
                    sup_d = svw_pkg::SVW_S_LOW;
                end
            end
            default: begin
                sup_d = svw_pkg::SVW_S_LOW;
            end
        endcase
        // RQ5 classify at probe end
        if (probe_busy_q) begin
            if (supply_low) begin
                probe_busy_d = 1'b0;
            end else if (probe_cnt >= PROBE_CYCLES - 26'h0001) begin
                probe_busy_d = 1'b0;
                if (probe_sense.cap_seen) begin
                    mode_d = svw_pkg::SVW_MODE_CAP;
                end else if (probe_sense.pulled_up) begin
                    mode_d = svw_pkg::SVW_MODE_PULL;
                end else begin
                    mode_d = svw_pkg::SVW_MODE_OPEN;
                end
            end
        end
        // RQ1 reset low unless running
        rst_n_d = (sup_d == svw_pkg::SVW_S_RUN);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sup_q <= svw_pkg::SVW_S_LOW;
            mode_q <= svw_pkg::SVW_MODE_NONE;
            probe_busy_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            sup_q <= sup_d;
            mode_q <= mode_d;
            probe_busy_q <= probe_busy_d;
            rst_n_q <= rst_n_d;
        end
    end

    svw_pkg::svw_wd_t wd_q, wd_d;
    logic kick_prev_q;
    logic fault_n_q, fault_n_d;
    logic restart_q;
    logic wd_clr;
    logic kick_fall;
    logic expired;
    logic [25:0] wd_cnt;
    logic [25:0] tmo_limit;

    // one counter serves settling, the kick interval and the fault pulse
    svw_cnt #(.W(svw_pkg::CNT_W)) u_wd_cnt (
        .clk(clk),
        .rst(rst),
        .clear(wd_clr),
        .run(1'b1),
        .count_q(wd_cnt)
    );

    // RQ7 falling edge only
    assign kick_fall = kick_prev_q && !kick_in;

    // RQ6 fixed timeout select
    always_comb begin
        case (mode_q)
            svw_pkg::SVW_MODE_OPEN: tmo_limit = TMO_OPEN_CYCLES;
            svw_pkg::SVW_MODE_PULL: tmo_limit = TMO_PULL_CYCLES;
            default: tmo_limit = TMO_OPEN_CYCLES;
        endcase
    end

    // RQ19 capacitor ends interval
    assign expired = (mode_q == svw_pkg::SVW_MODE_CAP) ? charge_done :
        ((mode_q != svw_pkg::SVW_MODE_NONE) && (wd_cnt >= tmo_limit - 26'h0001));

    // watchdog sequencing; kicks during settle and fault pulse are dropped
    always_comb begin
        wd_d = wd_q;
        wd_clr = 1'b0;
        // follow the next supply state, so the fault pin lets go on the
        // same edge that the system reset pin asserts, never a cycle later
        if (sup_d != svw_pkg::SVW_S_RUN) begin
            // RQ10 off during reset
            wd_d = svw_pkg::SVW_W_OFF;
            wd_clr = 1'b1;
        end else begin
            case (wd_q)
                svw_pkg::SVW_W_OFF: begin
                    // RQ11 resume after release
                    wd_clr = 1'b1;
                    wd_d = wdog_enable ? svw_pkg::SVW_W_RUN : svw_pkg::SVW_W_DIS;
                end
                svw_pkg::SVW_W_DIS: begin
                    // RQ14 disabled ignores kicks
                    wd_clr = 1'b1;
                    if (wdog_enable) begin
                        wd_d = svw_pkg::SVW_W_SETTLE;
                    end
                end
                svw_pkg::SVW_W_SETTLE: begin
                    // RQ16 settle before kicks count
                    if (!wdog_enable) begin
                        wd_d = svw_pkg::SVW_W_DIS;
                        wd_clr = 1'b1;
                    end else if (wd_cnt >= SETTLE_CYCLES - 26'h0001) begin
                        wd_d = svw_pkg::SVW_W_RUN;
                        wd_clr = 1'b1;
                    end
                end
                svw_pkg::SVW_W_RUN: begin
                    // RQ15 RQ8 RQ9 RQ18 timed kicks
                    if (!wdog_enable) begin
                        wd_d = svw_pkg::SVW_W_DIS;
                        wd_clr = 1'b1;
                    end else if (kick_fall) begin
                        wd_clr = 1'b1;
                    end else if (expired) begin
                        wd_d = svw_pkg::SVW_W_FAULT;
                        wd_clr = 1'b1;
                    end
                end
                svw_pkg::SVW_W_FAULT: begin
                    // RQ12 RQ20 pulse then restart
                    if (!wdog_enable) begin
                        wd_d = svw_pkg::SVW_W_DIS;
                        wd_clr = 1'b1;
                    end else if (wd_cnt >= HOLD_CYCLES - 26'h0001) begin
                        wd_d = svw_pkg::SVW_W_RUN;
                        wd_clr = 1'b1;
                    end
                end
                default: begin
                    wd_d = svw_pkg::SVW_W_OFF;
                    wd_clr = 1'b1;
                end
            endcase
        end
        // RQ13 released unless faulting
        fault_n_d = (wd_d != svw_pkg::SVW_W_FAULT);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wd_q <= svw_pkg::SVW_W_OFF;
            kick_prev_q <= 1'b1;
            fault_n_q <= 1'b1;
            restart_q <= 1'b0;
        end else begin
            wd_q <= wd_d;
            kick_prev_q <= kick_in;
            fault_n_q <= fault_n_d;
            restart_q <= wd_clr && (wd_q == svw_pkg::SVW_W_RUN || wd_d == svw_pkg::SVW_W_RUN);
        end
    end

    // outputs straight from flops, wdog_active decoded from wd_q; open-drain enables mirror the low level
    assign system_reset_out_n = rst_n_q;
    assign system_reset_oe = !rst_n_q;
    assign wdog_fault_out_n = fault_n_q;
    assign wdog_fault_oe = !fault_n_q;
    assign timeout_mode = mode_q;
    assign wdog_active = (wd_q == svw_pkg::SVW_W_RUN);
    assign charge_restart = restart_q;

endmodule // svw_core

// file: design/svw_pkg.sv
// svw_pkg: constants, state encodings and carriers for the supervisor watchdog core.
// assumes a single 25 MHz clock; every time below is turned into clock cycles here.
package svw_pkg;

    // clock rate in kHz so that ms and us conversions stay well inside 32 bits
    localparam int unsigned CLK_KHZ = 25000;
    localparam int unsigned CNT_W = 26;

    // reset hold after supply valid, also the fault pulse length (nominal)
    localparam int unsigned HOLD_MS = 200;
    localparam int unsigned HOLD_CYC = HOLD_MS * CLK_KHZ;
    // timeout-select pin probe time, least time rounded up
    localparam int unsigned PROBE_US = 390;
    localparam int unsigned PROBE_CYC = (PROBE_US * CLK_KHZ + 999) / 1000;
    // settling after the enable pin goes from low to high, rounded up
    localparam int unsigned SETTLE_US = 140;
    localparam int unsigned SETTLE_CYC = (SETTLE_US * CLK_KHZ + 999) / 1000;
    // fixed watchdog timeouts for an open or pulled-up select pin
    localparam int unsigned TMO_OPEN_MS = 1600;
    localparam int unsigned TMO_OPEN_CYC = TMO_OPEN_MS * CLK_KHZ;
    localparam int unsigned TMO_PULL_MS = 200;
    localparam int unsigned TMO_PULL_CYC = TMO_PULL_MS * CLK_KHZ;

    // classification of the timeout-select pin
    typedef enum logic [1:0] {
        SVW_MODE_NONE = 2'h0,
        SVW_MODE_OPEN = 2'h1,
        SVW_MODE_PULL = 2'h2,
        SVW_MODE_CAP = 2'h3
    } svw_mode_t;

    // supply sequencing states, one-hot
    typedef enum logic [2:0] {
        SVW_S_LOW = 3'h1,
        SVW_S_HOLD = 3'h2,
        SVW_S_RUN = 3'h4
    } svw_sup_t;

    // watchdog states, one-hot
    typedef enum logic [4:0] {
        SVW_W_OFF = 5'h01,
        SVW_W_DIS = 5'h02,
        SVW_W_SETTLE = 5'h04,
        SVW_W_RUN = 5'h08,
        SVW_W_FAULT = 5'h10
    } svw_wd_t;

    // what the analog probe of the timeout-select pin reports
    typedef struct packed {
        logic cap_seen;
        logic pulled_up;
    } svw_probe_t;

endpackage

// file: tb/svw_host.sv
// svw_host: host processor model kicking the watchdog with falling edges.
// assumes gap of at least 1, so every kick has a high cycle before its fall.
`timescale 1ns/1ns
module svw_host (
    input wire logic clk,
    input wire logic go,
    input wire logic park_hi,
    input wire logic [7:0] gap,
    output logic kick_in
);
    logic [7:0] cnt_q;
    initial kick_in = 1'b0;
    // kick each window, solid idle level
    always @(posedge clk) begin
        if (!go) begin
            cnt_q <= 8'h00;
            kick_in <= park_hi;
        end else if (cnt_q >= gap) begin
            cnt_q <= 8'h00;
            kick_in <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            kick_in <= (cnt_q == gap - 8'h01);
        end
    end
endmodule // svw_host

// file: tb/svw_monitor.sv
// svw_monitor: concurrent checks on the ports of svw_core.
// assumes one clock and a synchronous active-high reset; bound below.
`timescale 1ns/1ns
module svw_monitor #(
    parameter logic [25:0] HOLD_CYCLES = 26'(svw_pkg::HOLD_CYC),
    parameter logic [25:0] PROBE_CYCLES = 26'(svw_pkg::PROBE_CYC),
    parameter logic [25:0] TMO_OPEN_CYCLES = 26'(svw_pkg::TMO_OPEN_CYC),
    parameter logic [25:0] TMO_PULL_CYCLES = 26'(svw_pkg::TMO_PULL_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_low,
    input wire logic supply_valid,
    input wire svw_pkg::svw_probe_t probe_sense,
    input wire logic wdog_enable,
    input wire logic kick_in,
    input wire logic charge_done,
    input wire logic system_reset_out_n,
    input wire logic system_reset_oe,
    input wire logic wdog_fault_out_n,
    input wire logic wdog_fault_oe,
    input wire svw_pkg::svw_mode_t timeout_mode,
    input wire logic wdog_active,
    input wire logic charge_restart
);
    logic [25:0] fcnt_q, fcnt_d, vcnt_q, vcnt_d;
    // length of the fault pulse and of the good-supply run; wrap comes after about 2.7 s
    always_comb begin
        fcnt_d = wdog_fault_out_n ? 26'h000_0000 : fcnt_q + 26'h000_0001;
        vcnt_d = supply_low ? 26'h000_0000 : vcnt_q + 26'h000_0001;
    end
    // helper registers
    always_ff @(posedge clk) begin
        fcnt_q <= rst ? 26'h000_0000 : fcnt_d;
        vcnt_q <= rst ? 26'h000_0000 : vcnt_d;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // pin and watchdog relations
    a_low_resets: assert property (supply_low |=> !system_reset_out_n)
        else $error("reset not asserted on low supply");
    a_hold_length: assert property ($rose(system_reset_out_n) |-> vcnt_q >= HOLD_CYCLES)
        else $error("reset released before hold time");
    a_mode_ready: assert property ($rose(system_reset_out_n) |-> timeout_mode != 2'h0)
        else $error("select pin not classified at release");
    a_quiet_reset: assert property (!system_reset_out_n |->
        !wdog_active && wdog_fault_out_n && !wdog_fault_oe)
        else $error("watchdog busy during reset");
    a_enable_off: assert property (!wdog_enable |=> !wdog_active && wdog_fault_out_n)
        else $error("watchdog runs while disabled");
    a_settle_wait: assert property ($rose(wdog_enable) |=> !wdog_active [*8])
        else $error("watchdog active during settle");
    a_kick_restart: assert property (wdog_active && $past(kick_in) && !kick_in
        |-> ##[1:2] charge_restart)
        else $error("falling kick did not restart interval");
    a_fault_length: assert property ($rose(wdog_fault_out_n) && system_reset_out_n
        && $past(wdog_enable) |-> fcnt_q == HOLD_CYCLES)
        else $error("fault pulse length wrong");
    // a kick, a supply drop or a disable on the same edge rightly wins over charge done
    a_cap_done: assert property (wdog_active && charge_done && timeout_mode == 2'h3
        && !supply_low && wdog_enable && !($past(kick_in) && !kick_in)
        |=> !wdog_fault_out_n)
        else $error("charge done did not raise fault");
    // main scenarios reached
    cover property ($fell(wdog_fault_out_n));
    cover property ($rose(system_reset_out_n));
    cover property (charge_restart);
endmodule // svw_monitor

bind svw_core svw_monitor #(.HOLD_CYCLES(HOLD_CYCLES), .PROBE_CYCLES(PROBE_CYCLES),
    .TMO_OPEN_CYCLES(TMO_OPEN_CYCLES), .TMO_PULL_CYCLES(TMO_PULL_CYCLES)) u_mon (
    .clk, .rst, .supply_low, .supply_valid, .probe_sense, .wdog_enable, .kick_in,
    .charge_done, .system_reset_out_n, .system_reset_oe, .wdog_fault_out_n,
    .wdog_fault_oe, .timeout_mode, .wdog_active, .charge_restart);

// file: tb/test_supervisor_watchdog_core.sv
// test_supervisor_watchdog_core: self-checking bench for svw_core.
// assumes short hold and timeout counts; the enable settle keeps full length.
`timescale 1ns/1ns
module test_supervisor_watchdog_core;
    localparam int HOLD = 40;
    localparam int TO = 60;
    localparam int TP = 30;
    logic clk, rst = 1'b1, supply_low = 1'b1, supply_valid = 1'b0, kick_in;
    logic wdog_enable = 1'b1, charge_done = 1'b0, go = 1'b0, park_hi = 1'b0, bad = 1'b0;
    logic system_reset_out_n, system_reset_oe, wdog_fault_out_n, wdog_fault_oe;
    logic wdog_active, charge_restart;
    logic [7:0] gap = 8'h04;
    svw_pkg::svw_probe_t probe_sense = 2'h0;
    svw_pkg::svw_mode_t timeout_mode;
    int errors = 0;
    int check_count = 0;
    int n;
    // design with shortened counts, host model on the kick pin
    svw_core #(.HOLD_CYCLES(26'(HOLD)), .PROBE_CYCLES(26'h000_000a),
        .TMO_OPEN_CYCLES(26'(TO)), .TMO_PULL_CYCLES(26'(TP))) DUT (.clk, .rst,
        .supply_low, .supply_valid, .probe_sense, .wdog_enable, .kick_in, .charge_done,
        .system_reset_out_n, .system_reset_oe, .wdog_fault_out_n, .wdog_fault_oe,
        .timeout_mode, .wdog_active, .charge_restart);
    svw_host u_host (.clk, .go, .park_hi, .gap, .kick_in);
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
    endtask
    // a late rising kick edge must not restart the interval being timed
    task automatic wait_fault();
        n = 0;
        go <= 1'b0;
        park_hi <= 1'b0;
        while (wdog_fault_out_n !== 1'b0 && n < 3000) begin
            step(1);
            n++;
            if (n == 10)
                park_hi <= 1'b1;
        end
    endtask
    task automatic power_up(input svw_pkg::svw_probe_t p, input svw_pkg::svw_mode_t m);
        supply_low <= 1'b1;
        supply_valid <= 1'b0;
        probe_sense <= p;
        step(3);
        check(system_reset_out_n, 1'b0);
        supply_low <= 1'b0;
        supply_valid <= 1'b1;
        n = 0;
        while (system_reset_out_n !== 1'b1 && n < 500) begin
            step(1);
            n++;
        end
        check(n >= HOLD + 1 && n <= HOLD + 3, 1'b1);
        check(timeout_mode, m);
        check(wdog_active, 1'b1);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, several times the expected run
    initial begin
        #(20000 * 40);
        errors++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h9ea2_8759));
        step(2);
        rst <= 1'b0;
        // open pin: long fixed timeout, then a full pulse and timing again
        power_up(2'h0, svw_pkg::SVW_MODE_OPEN);
        wait_fault();
        check(n + 2 >= TO && n <= TO + 2, 1'b1);
        n = 0;
        while (wdog_fault_out_n !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        check(n, HOLD);
        step(1);
        check(wdog_active, 1'b1);
        // pulled-up pin: random kick spacing, gap 1 is the tightest legal one
        power_up(2'h1, svw_pkg::SVW_MODE_PULL);
        for (int i = 0; i < 5; i++) begin
            // a gap change mid-count adds old and new spacing; keep each under half
            gap <= (i == 0) ? 8'h01 : 8'(2 + $urandom % ((TP - 8) / 2));
            go <= 1'b1;
            repeat (120) begin
                step(1);
                bad = bad | (wdog_fault_out_n !== 1'b1);
            end
        end
        check(bad, 1'b0);
        // stop right after a falling edge; timeout counts from that edge
        while (kick_in !== 1'b1)
            step(1);
        while (kick_in !== 1'b0)
            step(1);
        wait_fault();
        check(n + 2 >= TP && n <= TP + 2, 1'b1);
        // enable low drops pulse and timer; enabling waits out the settle
        wdog_enable <= 1'b0;
        step(TP * 3);
        check({wdog_fault_out_n, wdog_active}, 2'b10);
        wdog_enable <= 1'b1;
        step(3490);
        check(wdog_active, 1'b0);
        step(30);
        check(wdog_active, 1'b1);
        // supply drop in the first cycle of the pulse while the host keeps kicking
        wait_fault();
        go <= 1'b1;
        supply_low <= 1'b1;
        step(3);
        check({system_reset_out_n, wdog_fault_out_n, wdog_fault_oe}, 3'b010);
        // capacitor wins over pull-up; only charge_done ends the interval
        power_up(2'h3, svw_pkg::SVW_MODE_CAP);
        go <= 1'b0;
        step(TO * 2);
        check(wdog_fault_out_n, 1'b1);
        charge_done <= 1'b1;
        step(1);
        charge_done <= 1'b0;
        step(2);
        check(wdog_fault_out_n, 1'b0);
        complete_run();
    end
endmodule // test_supervisor_watchdog_core
